// >>> logic/bit_engine.sv
`timescale 1ns/100ps
module bit_engine
  import two_wire_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command side
  bit_if.eng       bus
);
  logic             run_ff, nxt_run;
  logic [1:0]       ph_ff, nxt_ph;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  bit_cmd_e         cmd_ff, nxt_cmd;
  logic             bit_ff, nxt_bit;
  logic             scl_rel_ff, nxt_scl_rel;
  logic             sda_rel_ff, nxt_sda_rel;
  logic             done_ff, nxt_done;
  logic             lost_ff, nxt_lost;
  logic             rbit_ff, nxt_rbit;
  logic             busy_ff, nxt_busy;
  logic             scl_d_ff, sda_d_ff;

  // line release per command phase; sda moves under a high clock only for start and stop
  function automatic logic [1:0] lines(bit_cmd_e c, logic [1:0] p, logic b, logic scl_now);
    logic [1:0] r;
    r = 2'h3;
    unique case (c)
      CMD_START: r = (p == 2'h0) ? {scl_now, 1'b1} : (p == 2'h1) ? 2'h3 :
                     (p == 2'h2) ? 2'h2 : 2'h0;
      CMD_STOP:  r = (p == 2'h0) ? 2'h0 : (p == 2'h1) ? 2'h2 : 2'h3;
      CMD_WRITE: r = {(p == 2'h1) || (p == 2'h2), b};
      CMD_READ:  r = {(p == 2'h1) || (p == 2'h2), 1'b1};
    endcase
    return r;
  endfunction : lines

  always_comb begin
    nxt_run     = run_ff;
    nxt_ph      = ph_ff;
    nxt_cnt     = cnt_ff;
    nxt_cmd     = cmd_ff;
    nxt_bit     = bit_ff;
    nxt_scl_rel = scl_rel_ff;
    nxt_sda_rel = sda_rel_ff;
    nxt_done    = 1'b0;
    nxt_lost    = lost_ff;
    nxt_rbit    = rbit_ff;
    nxt_busy    = busy_ff;
    // a start or stop seen from any master marks the bus busy or free
    if (bus.scl_in && scl_d_ff && sda_d_ff && !bus.sda_in) nxt_busy = 1'b1;
    if (bus.scl_in && scl_d_ff && !sda_d_ff && bus.sda_in) nxt_busy = 1'b0;
    if (!run_ff) begin
      if (bus.req && !done_ff) begin
        nxt_run  = 1'b1;
        nxt_ph   = 2'h0;
        nxt_cnt  = '0;
        nxt_cmd  = bus.cmd;
        nxt_bit  = bus.wbit;
        nxt_lost = 1'b0;
      end
    end else begin
      {nxt_scl_rel, nxt_sda_rel} = lines(cmd_ff, ph_ff, bit_ff, scl_rel_ff); // RULE23
      // a slave stretching the clock holds the high phase back
      if (!(ph_ff == 2'h1 && !bus.scl_in)) nxt_cnt = cnt_ff + 1'b1;
      if (cnt_ff == CNT_W'(QUARTER - 1)) begin
        nxt_cnt = '0;
        nxt_ph  = ph_ff + 1'b1;
        if (ph_ff == 2'h2) begin
          nxt_rbit = bus.sda_in;
          if (cmd_ff == CMD_WRITE && bit_ff && !bus.sda_in) begin
            nxt_lost    = 1'b1;
            nxt_run     = 1'b0;
            nxt_done    = 1'b1;
            nxt_scl_rel = 1'b1;
            nxt_sda_rel = 1'b1;
          end
        end
        if (ph_ff == 2'h3) begin
          nxt_run  = 1'b0;
          nxt_done = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      run_ff     <= 1'b0;
      ph_ff      <= 2'h0;
      cnt_ff     <= '0;
      cmd_ff     <= CMD_START;
      bit_ff     <= 1'b1;
      scl_rel_ff <= 1'b1;
      sda_rel_ff <= 1'b1;
      done_ff    <= 1'b0;
      lost_ff    <= 1'b0;
      rbit_ff    <= 1'b1;
      busy_ff    <= 1'b0;
      scl_d_ff   <= 1'b1;
      sda_d_ff   <= 1'b1;
    end else begin
      run_ff     <= nxt_run;
      ph_ff      <= nxt_ph;
      cnt_ff     <= nxt_cnt;
      cmd_ff     <= nxt_cmd;
      bit_ff     <= nxt_bit;
      scl_rel_ff <= nxt_scl_rel;
      sda_rel_ff <= nxt_sda_rel;
      done_ff    <= nxt_done;
      lost_ff    <= nxt_lost;
      rbit_ff    <= nxt_rbit;
      busy_ff    <= nxt_busy;
      scl_d_ff   <= bus.scl_in;
      sda_d_ff   <= bus.sda_in;
    end
  end

  assign bus.done    = done_ff;
  assign bus.lost    = lost_ff;
  assign bus.rbit    = rbit_ff;
  assign bus.busy    = busy_ff;
  assign bus.scl_rel = scl_rel_ff;
  assign bus.sda_rel = sda_rel_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_start_edge: assert property ( // RULE23
    (run_ff && cmd_ff == CMD_START && $fell(sda_rel_ff)) |-> scl_rel_ff)
    else $error("start edge not under high clock");
  chk_data_edge: assert property ( // RULE23
    (run_ff && $past(run_ff) && cmd_ff inside {CMD_WRITE, CMD_READ} && $changed(sda_rel_ff))
      |-> !scl_rel_ff)
    else $error("data line moved while clock high");
endmodule : bit_engine

// >>> logic/bit_if.sv
`timescale 1ns/100ps
interface bit_if;
  import two_wire_pkg::*;
  logic     req;
  bit_cmd_e cmd;
  logic     wbit;
  logic     done;
  logic     lost;
  logic     rbit;
  logic     busy;
  logic     scl_rel;
  logic     sda_rel;
  logic     scl_in;
  logic     sda_in;
  modport eng (input req, cmd, wbit, scl_in, sda_in,
               output done, lost, rbit, busy, scl_rel, sda_rel);
  modport ctl (output req, cmd, wbit, scl_in, sda_in,
               input done, lost, rbit, busy, scl_rel, sda_rel);
endinterface : bit_if

// >>> logic/two_wire_master.sv
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
// Function
// RULE1: software starts with flag, start, enable set
// RULE2: start only once the bus is free
// RULE3: after start set flag, status 08
// RULE4: address direction bit selects transmitter or receiver
// RULE5: address write: 18 on ack, 20 otherwise
// RULE6: data sent: 28 on ack, 30 otherwise
// RULE7: flag clear, no start/stop: send byte
// RULE8: start alone gives repeated start, bus kept
// RULE9: stop alone sends stop, clears stop bit
// RULE10: start and stop: stop, then start
// RULE11: lost arbitration gives 38; release bus
// RULE12: 38 with start: start when bus free
// RULE13: address read: 40, 48 or 38
// RULE14: receive byte, ack per acknowledge enable
// RULE15: byte received: 50 after ack, 58 otherwise
// RULE16: received byte readable while flag set
// RULE17: software ends read with not-ack, stop
// RULE18: repeated start gives 10, then either mode
// RULE19: writing one clears flag, transfer continues
// RULE20: status codes valid with prescaler masked
// RULE21: bus held while flag is set
// RULE22: data write with flag low: discard, collide
// RULE23: start and stop formed under high clock
// RULE24: idle shows F8, start and stop clear
module two_wire_master
  import two_wire_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // serial bus, open drain
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_n,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_WAIT = 3'h1,
    ST_START = 3'h2,
    ST_BITS = 3'h3,
    ST_ACK = 3'h4,
    ST_STOP = 3'h5,
    ST_HOLD = 3'h6
  } main_state_e;

  bit_if bif ();

  logic               scl_m_ff, scl_s_ff, sda_m_ff, sda_s_ff;
  logic               zero_ff;
  main_state_e        state_ff, nxt_state;
  logic               flag_ff, nxt_flag;
  logic               acken_ff, nxt_acken;
  logic               sta_ff, nxt_sta;
  logic               sto_ff, nxt_sto;
  logic               wc_ff, nxt_wc;
  logic               en_ff, nxt_en;
  logic               ie_ff, nxt_ie;
  logic [PRESC_W-1:0] presc_ff, nxt_presc;
  logic [7:0]         code_ff, nxt_code;
  logic [7:0]         data_ff, nxt_data;
  logic [7:0]         shift_ff, nxt_shift;
  logic [2:0]         bitn_ff, nxt_bitn;
  logic               tx_ff, nxt_tx;
  logic               rxm_ff, nxt_rxm;
  logic               addr_ff, nxt_addr;
  logic               ackd_ff, nxt_ackd;
  logic               rst_ff, nxt_rst;
  logic               req_ff, nxt_req;
  bit_cmd_e           cmd_ff, nxt_cmd;
  logic               wbit_ff, nxt_wbit;
  logic [31:0]        prdata_ff, nxt_prdata;
  logic               pready_ff, nxt_pready;
  logic               pslverr_ff, nxt_pslverr;
  logic               acc, wr_ctrl, wr_data, go, ackd;

  assign acc     = psel && penable && pready_ff;
  assign wr_ctrl = acc && pwrite && paddr == ADDR_CTRL;
  assign wr_data = acc && pwrite && paddr == ADDR_DATA;
  // the transfer only advances when the flag is written to one with the unit enabled
  assign go      = wr_ctrl && pwdata[B_FLAG] && pwdata[B_EN]; // RULE1 RULE19
  assign ackd    = !bif.rbit;

  // apb: one wait state, read data and error registered with pready
  always_comb begin
    nxt_pready  = psel && penable && !pready_ff;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = 1'b0;
    if (psel && penable && !pready_ff) begin
      unique case (paddr)
        ADDR_CTRL: nxt_prdata = {24'h000000, flag_ff, acken_ff, sta_ff, sto_ff,
                                 wc_ff, en_ff, 1'b0, ie_ff};
        ADDR_STAT: nxt_prdata = {24'h000000, code_ff[7:3], 1'b0, presc_ff}; // RULE20
        ADDR_DATA: nxt_prdata = {24'h000000, data_ff}; // RULE16
        default: begin
          nxt_prdata  = 32'h00000000;
          nxt_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= nxt_pready;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // byte sequencer and registers
  always_comb begin
    nxt_state = state_ff;
    nxt_flag  = flag_ff;
    nxt_acken = acken_ff;
    nxt_sta   = sta_ff;
    nxt_sto   = sto_ff;
    nxt_wc    = wc_ff;
    nxt_en    = en_ff;
    nxt_ie    = ie_ff;
    nxt_presc = presc_ff;
    nxt_code  = code_ff;
    nxt_data  = data_ff;
    nxt_shift = shift_ff;
    nxt_bitn  = bitn_ff;
    nxt_tx    = tx_ff;
    nxt_rxm   = rxm_ff;
    nxt_addr  = addr_ff;
    nxt_ackd  = ackd_ff;
    nxt_rst   = rst_ff;
    nxt_req   = req_ff;
    nxt_cmd   = cmd_ff;
    nxt_wbit  = wbit_ff;
    if (bif.done) nxt_req = 1'b0;
    if (wr_ctrl) begin
      nxt_acken = pwdata[B_ACKEN];
      nxt_sta   = pwdata[B_STA];
      nxt_sto   = pwdata[B_STO];
      nxt_en    = pwdata[B_EN];
      nxt_ie    = pwdata[B_IE];
      if (pwdata[B_FLAG]) nxt_flag = 1'b0; // RULE19
    end
    if (acc && pwrite && paddr == ADDR_STAT) nxt_presc = pwdata[PRESC_W-1:0];
    if (wr_data) begin
      if (flag_ff) begin
        nxt_data = pwdata[7:0];
        nxt_wc   = 1'b0;
      end else begin
        nxt_wc = 1'b1; // RULE22
      end
    end
    unique case (state_ff)
      ST_IDLE: begin
        nxt_code = C_IDLE; // RULE24
        if (go && pwdata[B_STA]) nxt_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (!bif.busy) begin // RULE2 RULE12
          nxt_state = ST_START;
          nxt_req   = 1'b1;
          nxt_cmd   = CMD_START;
          nxt_rst   = 1'b0;
        end
      end
      ST_HOLD: begin
        // nothing is launched while the flag stands
        if (go) begin // RULE21
          if (pwdata[B_STO]) begin
            nxt_state = ST_STOP; // RULE9 RULE10
            nxt_req   = 1'b1;
            nxt_cmd   = CMD_STOP;
          end else if (pwdata[B_STA]) begin
            if (code_ff == C_ARB) begin
              nxt_state = ST_WAIT; // RULE12
            end else begin
              nxt_state = ST_START; // RULE8
              nxt_req   = 1'b1;
              nxt_cmd   = CMD_START;
              nxt_rst   = 1'b1;
            end
          end else if (code_ff == C_ARB) begin
            nxt_state = ST_IDLE; // RULE11
            nxt_code  = C_IDLE; // RULE24
          end else if (code_ff inside {C_START, C_RSTART, C_AW_ACK, C_AW_NAK,
                                       C_DW_ACK, C_DW_NAK}) begin
            nxt_state = ST_BITS; // RULE7
            nxt_shift = data_ff;
            nxt_bitn  = 3'h0;
            nxt_tx    = 1'b1;
            nxt_req   = 1'b1;
            nxt_cmd   = CMD_WRITE;
            nxt_wbit  = data_ff[7];
            if (code_ff inside {C_START, C_RSTART}) begin
              nxt_addr = 1'b1;
              nxt_rxm  = data_ff[0]; // RULE4 RULE18
            end
          end else if (code_ff inside {C_AR_ACK, C_DR_ACK}) begin
            nxt_state = ST_BITS; // RULE14
            nxt_bitn  = 3'h0;
            nxt_tx    = 1'b0;
            nxt_req   = 1'b1;
            nxt_cmd   = CMD_READ;
          end
        end
      end
      ST_START: begin
        if (bif.done) begin
          nxt_flag  = 1'b1;
          nxt_state = ST_HOLD;
          nxt_code  = bif.lost ? C_ARB : rst_ff ? C_RSTART : C_START; // RULE3 RULE18
        end
      end
      ST_BITS: begin
        if (bif.done) begin
          if (bif.lost) begin
            nxt_flag  = 1'b1; // RULE11
            nxt_code  = C_ARB;
            nxt_state = ST_HOLD;
          end else begin
            nxt_shift = tx_ff ? {shift_ff[6:0], 1'b0} : {shift_ff[6:0], bif.rbit};
            nxt_bitn  = bitn_ff + 1'b1;
            nxt_req   = 1'b1;
            if (bitn_ff == LAST_BIT) begin
              nxt_state = ST_ACK;
              nxt_cmd   = tx_ff ? CMD_READ : CMD_WRITE;
              nxt_wbit  = !acken_ff; // RULE14
              nxt_ackd  = acken_ff;
            end else begin
              nxt_cmd  = tx_ff ? CMD_WRITE : CMD_READ;
              nxt_wbit = shift_ff[6];
            end
          end
        end
      end
      ST_ACK: begin
        if (bif.done) begin
          nxt_flag  = 1'b1;
          nxt_state = ST_HOLD;
          nxt_addr  = 1'b0;
          if (bif.lost) begin
            nxt_code = C_ARB; // RULE13
          end else if (!tx_ff) begin
            nxt_data = shift_ff; // RULE16
            nxt_code = ackd_ff ? C_DR_ACK : C_DR_NAK; // RULE15
          end else if (addr_ff) begin
            nxt_code = rxm_ff ? (ackd ? C_AR_ACK : C_AR_NAK)  // RULE13
                              : (ackd ? C_AW_ACK : C_AW_NAK); // RULE5
          end else begin
            nxt_code = ackd ? C_DW_ACK : C_DW_NAK; // RULE6
          end
        end
      end
      ST_STOP: begin
        if (bif.done) begin
          nxt_sto   = 1'b0; // RULE9 RULE10
          nxt_state = sta_ff ? ST_WAIT : ST_IDLE; // RULE10
          nxt_code  = C_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    // a flag raised by the bus in the same cycle as a software clear stays set
    if (state_ff != ST_HOLD && nxt_state == ST_HOLD) nxt_flag = 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      flag_ff  <= 1'b0;
      acken_ff <= 1'b0;
      sta_ff   <= 1'b0;
      sto_ff   <= 1'b0;
      wc_ff    <= 1'b0;
      en_ff    <= 1'b0;
      ie_ff    <= 1'b0;
      presc_ff <= '0;
      code_ff  <= C_IDLE;
      data_ff  <= RST_DATA;
      shift_ff <= 8'h00;
      bitn_ff  <= 3'h0;
      tx_ff    <= 1'b0;
      rxm_ff   <= 1'b0;
      addr_ff  <= 1'b0;
      ackd_ff  <= 1'b0;
      rst_ff   <= 1'b0;
      req_ff   <= 1'b0;
      cmd_ff   <= CMD_START;
      wbit_ff  <= 1'b1;
      zero_ff  <= 1'b0;
      scl_m_ff <= 1'b1;
      scl_s_ff <= 1'b1;
      sda_m_ff <= 1'b1;
      sda_s_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      flag_ff  <= nxt_flag;
      acken_ff <= nxt_acken;
      sta_ff   <= nxt_sta;
      sto_ff   <= nxt_sto;
      wc_ff    <= nxt_wc;
      en_ff    <= nxt_en;
      ie_ff    <= nxt_ie;
      presc_ff <= nxt_presc;
      code_ff  <= nxt_code;
      data_ff  <= nxt_data;
      shift_ff <= nxt_shift;
      bitn_ff  <= nxt_bitn;
      tx_ff    <= nxt_tx;
      rxm_ff   <= nxt_rxm;
      addr_ff  <= nxt_addr;
      ackd_ff  <= nxt_ackd;
      rst_ff   <= nxt_rst;
      req_ff   <= nxt_req;
      cmd_ff   <= nxt_cmd;
      wbit_ff  <= nxt_wbit;
      zero_ff  <= 1'b0;
      scl_m_ff <= scl_in;
      scl_s_ff <= scl_m_ff;
      sda_m_ff <= sda_in;
      sda_s_ff <= sda_m_ff;
    end
  end

  assign bif.req    = req_ff;
  assign bif.cmd    = cmd_ff;
  assign bif.wbit   = wbit_ff;
  assign bif.scl_in = scl_s_ff;
  assign bif.sda_in = sda_s_ff;

  bit_engine #(.QUARTER(QUARTER)) u_eng (
    .clk (sys_clk),
    .rst (rst),
    .bus (bif.eng)
  );

  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign scl_out  = zero_ff;
  assign sda_out  = zero_ff;
  assign scl_oe_n = bif.scl_rel;
  assign sda_oe_n = bif.sda_rel;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence seq_stop_done;
    state_ff == ST_STOP ##0 bif.done;
  endsequence
  sequence seq_first_start;
    state_ff == ST_START && !rst_ff ##0 bif.done && !bif.lost;
  endsequence

  chk_start_code: assert property (seq_first_start |=> flag_ff && code_ff == C_START) // RULE3
    else $error("start did not report 08");
  chk_wait_free: assert property ((state_ff == ST_WAIT && bif.busy) |=> state_ff != ST_START) // RULE2
    else $error("start issued on a busy bus");
  chk_hold_quiet: assert property ((state_ff == ST_HOLD && !go) |=> !req_ff) // RULE21
    else $error("bus advanced while flag set");
  chk_wc_discard: assert property ((wr_data && !flag_ff) |=> wc_ff && $stable(data_ff)) // RULE22
    else $error("data write with flag low not discarded");
  chk_flag_clear: assert property ((wr_ctrl && pwdata[B_FLAG] && state_ff == ST_HOLD) // RULE19
    |=> !flag_ff)
    else $error("flag not cleared by write of one");
  chk_stop_clr: assert property (seq_stop_done |=> !sto_ff && code_ff == C_IDLE) // RULE9
    else $error("stop request not cleared after stop");
  chk_idle_code: assert property ($rose(state_ff == ST_IDLE) |-> code_ff == C_IDLE && !sto_ff) // RULE24
    else $error("idle without no-state code");
  chk_rx_code: assert property ((state_ff == ST_ACK && !tx_ff && bif.done && !bif.lost) // RULE15
    |=> code_ff == (ackd_ff ? C_DR_ACK : C_DR_NAK) && data_ff == $past(shift_ff))
    else $error("receive status or data wrong");
endmodule : two_wire_master

// >>> logic/two_wire_pkg.sv
package two_wire_pkg;
  // register byte addresses
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_DATA = 12'h008;
  // control register bit positions
  localparam int B_FLAG  = 7;
  localparam int B_ACKEN = 6;
  localparam int B_STA   = 5;
  localparam int B_STO   = 4;
  localparam int B_WC    = 3;
  localparam int B_EN    = 2;
  localparam int B_IE    = 0;
  localparam int PRESC_W = 2;
  // status codes, prescaler bits zero
  localparam logic [7:0] C_START   = 8'h08;
  localparam logic [7:0] C_RSTART  = 8'h10;
  localparam logic [7:0] C_AW_ACK  = 8'h18;
  localparam logic [7:0] C_AW_NAK  = 8'h20;
  localparam logic [7:0] C_DW_ACK  = 8'h28;
  localparam logic [7:0] C_DW_NAK  = 8'h30;
  localparam logic [7:0] C_ARB     = 8'h38;
  localparam logic [7:0] C_AR_ACK  = 8'h40;
  localparam logic [7:0] C_AR_NAK  = 8'h48;
  localparam logic [7:0] C_DR_ACK  = 8'h50;
  localparam logic [7:0] C_DR_NAK  = 8'h58;
  localparam logic [7:0] C_IDLE    = 8'hF8;
  localparam logic [7:0] RST_DATA  = 8'hFF;
  // bus timing: quarter of a serial clock period
  localparam int QUARTER_NS  = 2500;
  localparam int CLK_NS      = 100;
  localparam int QUARTER_CYC = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W       = 16;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_STOP  = 2'h1,
    CMD_WRITE = 2'h2,
    CMD_READ  = 2'h3
  } bit_cmd_e;
endpackage : two_wire_pkg

// >>> verif/bus_slave_model.sv
`timescale 1ns/100ps
module bus_slave_model (
  // bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  // behaviour
  input  wire logic       nak,
  input  wire logic [7:0] rbyte,
  // observation
  output logic            pull,
  output logic [7:0]      got
);
  int         cnt   = -1;
  logic       first = 1'b0;
  logic       rd    = 1'b0;
  logic       mack  = 1'b0;
  logic [7:0] sh    = 8'h00;
  initial pull = 1'b0;
  // start and stop are sda edges under a high clock
  always @(negedge sda) if (scl === 1'b1) begin
    cnt = -1;
    first = 1'b1;
    rd = 1'b0;
    pull = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    cnt = -1;
    rd = 1'b0;
    pull = 1'b0;
  end
  always @(posedge scl) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    else mack = !sda;
  end
  // a byte loaded while the clock is held low puts its first bit out at once
  always @(rbyte) if (scl === 1'b0 && rd && cnt == 0) pull = !rbyte[7];
  // drive only while the clock is low, so no false start or stop is seen
  always @(negedge scl) begin
    if (cnt == 7) begin
      if (first) rd = sh[0];
      got = sh;
      pull = (first || !rd) && !nak;
      first = 1'b0;
      cnt = 8;
    end else begin
      if (cnt == 8 && rd && !mack) rd = 1'b0;
      cnt = (cnt == 8) ? 0 : cnt + 1;
      pull = rd && cnt < 8 && !rbyte[7 - cnt];
    end
  end
endmodule : bus_slave_model

// >>> verif/two_wire_master_tb.sv
`timescale 1ns/100ps
module two_wire_master_tb;
  import two_wire_pkg::*;
  // 4 * Q cycles of 100 ns, 3 cycles waiting for the synchronised clock and 2 idle cycles between bits give a 1300 ns serial clock
  localparam int Q = 2;
  logic        sys_clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        scl_out, scl_oe_n, sda_out, sda_oe_n, pull, grab, nak, rerr;
  logic [7:0]  rbyte, got;
  wire         scl = scl_oe_n;
  wire         sda = sda_oe_n & ~pull & ~grab;
  int          num_errors = 0;
  int          n_tests = 0;

  two_wire_master #(.QUARTER(Q)) i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n));
  bus_slave_model i_slave (.scl(scl), .sda(sda), .nak(nak), .rbyte(rbyte), .pull(pull),
    .got(got));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
    if (k >= 20) begin
      num_errors++;
      wrap_up();
    end
  endtask : apb

  task automatic go(input logic [7:0] c);
    apb(1'b1, ADDR_CTRL, c);
  endtask : go

  // poll control until the flag or the end of a stop, status masked to the code
  task automatic wait_ev(input logic stop, input logic [7:0] code);
    int k;
    k = 0;
    do begin
      apb(1'b0, ADDR_CTRL, 8'h00);
      k++;
    end while ((stop ? rdat[B_STO] : !rdat[B_FLAG]) !== 1'b0 && k < 300);
    if (k >= 300) begin
      num_errors++;
      wrap_up();
    end
    apb(1'b0, ADDR_STAT, 8'h00);
    chk("status", rdat & 32'hF8, {24'h0, code});
  endtask : wait_ev

  task automatic send(input logic [7:0] b, input logic [7:0] code);
    apb(1'b1, ADDR_DATA, b);
    go(8'h84);
    wait_ev(1'b0, code);
  endtask : send

  task automatic t_reset();
    apb(1'b0, ADDR_CTRL, 8'h00);
    chk("ctrl", rdat, 32'h0);
    apb(1'b0, ADDR_STAT, 8'h00);
    chk("status", rdat, 32'hF8);
    apb(1'b0, 12'h00C, 8'h00);
    chk("unmapped", {31'h0, rerr}, 32'h1);
    apb(1'b1, ADDR_DATA, 8'h5A);
    apb(1'b0, ADDR_CTRL, 8'h00);
    chk("collision", {31'h0, rdat[B_WC]}, 32'h1);
    apb(1'b0, ADDR_DATA, 8'h00);
    chk("data", rdat, 32'hFF);
    apb(1'b1, ADDR_STAT, 8'h03);
    apb(1'b0, ADDR_STAT, 8'h00);
    chk("prescaler", rdat, 32'hFB);
    chk("drive", {30'h0, scl_out, sda_out}, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_write();
    go(8'hA4);
    wait_ev(1'b0, C_START);
    send(8'hA0, C_AW_ACK);
    chk("address", {24'h0, got}, 32'hA0);
    send(8'h3C, C_DW_ACK);
    chk("byte", {24'h0, got}, 32'h3C);
    nak <= 1'b1;
    send(8'h55, C_DW_NAK);
    go(8'hA4);
    wait_ev(1'b0, C_RSTART);
    send(8'hA0, C_AW_NAK);
    go(8'h94);
    wait_ev(1'b1, C_IDLE);
    chk("lines", {30'h0, scl, sda}, 32'h3);
    $display("test write done");
  endtask : t_write

  task automatic t_read();
    nak <= 1'b0;
    rbyte <= 8'h96;
    go(8'hA4);
    wait_ev(1'b0, C_START);
    send(8'hA1, C_AR_ACK);
    go(8'hC4);
    wait_ev(1'b0, C_DR_ACK);
    apb(1'b0, ADDR_DATA, 8'h00);
    chk("rx", rdat, 32'h96);
    rbyte <= 8'h3D;
    go(8'h84);
    wait_ev(1'b0, C_DR_NAK);
    apb(1'b0, ADDR_DATA, 8'h00);
    chk("rx", rdat, 32'h3D);
    go(8'hB4);
    wait_ev(1'b0, C_START);
    apb(1'b0, ADDR_CTRL, 8'h00);
    chk("stop bit", {31'h0, rdat[B_STO]}, 32'h0);
    nak <= 1'b1;
    send(8'hA1, C_AR_NAK);
    go(8'h94);
    wait_ev(1'b1, C_IDLE);
    $display("test read done");
  endtask : t_read

  task automatic t_arb();
    nak <= 1'b0;
    go(8'hA4);
    wait_ev(1'b0, C_START);
    // a rival master holds data low while the clock is held low
    grab <= 1'b1;
    send(8'hA0, C_ARB);
    go(8'hA4);
    repeat (40) @(posedge sys_clk);
    apb(1'b0, ADDR_CTRL, 8'h00);
    chk("busy bus", {31'h0, rdat[B_FLAG]}, 32'h0);
    grab <= 1'b0;
    wait_ev(1'b0, C_START);
    // lose again, then give up the bus instead of retrying
    grab <= 1'b1;
    send(8'hA0, C_ARB);
    go(8'h84);
    grab <= 1'b0;
    wait_ev(1'b1, C_IDLE);
    chk("released", {30'h0, scl, sda}, 32'h3);
    $display("test arbitration done");
  endtask : t_arb

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    nak = 1'b0;
    grab = 1'b0;
    rbyte = 8'h00;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_write();
    t_read();
    t_arb();
    wrap_up();
  end
endmodule : two_wire_master_tb
